/* File: modbus_master_model.sv */
// Purpose: behavioural bus master that sends requests and collects reply characters
// Assumes: bitCyc and par are set by the bench to match the slave's format
// Notes: the receive side always samples 10 bits after the start, so no parity shows a stop
`timescale 1ns/1ps
module modbus_master_model
   import modbus_pkg::*;
(
   input  wire logic clock,
   output logic      rxLine,
   input  wire logic txLine
);
   int         bitCyc = 48;
   parity_t    par    = PAR_EVEN;
   logic [9:0] gotQ[$];
   logic [9:0] w;
   initial rxLine = 1'b1;
   task automatic put_bit(input logic b, input int n);
      @(posedge clock);
      #1 rxLine = b;
      repeat (n - 1) @(posedge clock);
   endtask : put_bit
   task automatic send_frame(input logic [7:0] q[$], input int pre);
      if (pre > 0) put_bit(1'b1, pre * bitCyc);
      foreach (q[k]) begin
         put_bit(1'b0, bitCyc);
         for (int i = 0; i < 8; i++) put_bit(q[k][i], bitCyc);
         if (par != PAR_NONE) put_bit((par == PAR_ODD) ? ~^q[k] : ^q[k], bitCyc);
         else put_bit(1'b1, bitCyc);
         put_bit(1'b1, bitCyc);
      end
   endtask : send_frame
   initial forever begin
      @(negedge clock);
      if (txLine === 1'b0) begin
         repeat (bitCyc / 2) @(negedge clock);
         for (int i = 0; i < 10; i++) begin
            repeat (bitCyc) @(negedge clock);
            w[i] = txLine;
         end
         gotQ.push_back(w);
      end
   end
endmodule : modbus_master_model

/* File: modbus_pkg.sv */
// Purpose: shared types, constants and helpers of the modbus rtu slave framer
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes: silence thresholds are kept in tenths of a character and converted to half-bit units
package modbus_pkg;

   localparam int CLK_HZ_DEFAULT = 125_000_000;
   localparam int CHAR_BITS      = 11;
   localparam int HALVES_PER_CHR = 2 * CHAR_BITS;
   localparam int SIL_GAP_TENTHS = 15;
   localparam int SIL_END_TENTHS = 35;
   localparam logic [6:0] SIL_GAP_HALVES = 7'(SIL_GAP_TENTHS * HALVES_PER_CHR / 10);
   localparam logic [6:0] SIL_END_HALVES = 7'(SIL_END_TENTHS * HALVES_PER_CHR / 10);
   localparam logic [3:0] LAST_BIT_IDX   = 4'(CHAR_BITS - 1);
   localparam logic [2:0] LAST_DATA_IDX  = 3'h7;

   localparam logic [7:0]  ADDR_BROADCAST = 8'h00;
   localparam logic [7:0]  ADDR_MAX       = 8'hF7;
   localparam logic [7:0]  FUNC_EXC_FLAG  = 8'h80;
   localparam logic [15:0] CRC_INIT       = 16'hFFFF;
   localparam logic [15:0] CRC_POLY       = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE    = 16'h0000;
   localparam logic [2:0]  MIN_FRAME_BYTES = 3'h4;
   localparam logic [2:0]  BAUD_RESET     = 3'h2;
   localparam int          TX_FIFO_DEPTH  = 8;

   typedef enum logic [1:0] {PAR_EVEN = 2'b00, PAR_ODD = 2'b01, PAR_NONE = 2'b10} parity_t;
   typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
                             RX_PAR = 3'b011, RX_STOP = 3'b100} rx_state_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_LOAD = 2'b10, TX_SEND = 2'b11} tx_state_t;
   typedef enum logic [2:0] {PH_ADDR = 3'b000, PH_FUNC = 3'b001, PH_EXC = 3'b010, PH_DATA = 3'b011,
                             PH_CRCLO = 3'b100, PH_CRCHI = 3'b101, PH_DONE = 3'b110} tx_phase_t;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } tx_word_t;

   typedef struct packed {
      logic [7:0] data;
      logic       first;
   } rx_byte_t;

   typedef struct packed {
      logic ok;
      logic broadcast;
      logic crcError;
      logic incomplete;
   } frame_status_t;

   typedef struct packed {
      parity_t       parity;
      logic [2:0]    baud;
      rx_state_t     rxState;
      logic [15:0]   rxCnt;
      logic [2:0]    rxIdx;
      logic [7:0]    rxShift;
      logic          rxErr;
      logic [15:0]   silCnt;
      logic [6:0]    silHalves;
      logic          inFrame;
      logic          gapped;
      logic          frameBad;
      logic          addrMatch;
      logic          broadcast;
      logic [2:0]    byteCnt;
      logic [15:0]   crc;
      logic [7:0]    reqFunc;
      rx_byte_t      rxOut;
      logic          rxValid;
      logic          frameDone;
      frame_status_t status;
      logic          respondPending;
      tx_state_t     txState;
      tx_phase_t     txPhase;
      logic [15:0]   txCnt;
      logic [3:0]    txIdx;
      logic [10:0]   txShift;
      logic          txLine;
      logic          txDriveEn;
      logic          txExc;
      logic [7:0]    txExcCode;
      logic [15:0]   txCrc;
   } framer_state_t;

   localparam framer_state_t FRAMER_RESET = '{parity: PAR_EVEN, baud: BAUD_RESET, rxState: RX_IDLE,
                                              txState: TX_IDLE, txPhase: PH_ADDR, txLine: 1'b1, default: '0};

   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc16_byte

   function automatic logic par_bit(input parity_t p, input logic [7:0] b);
      return (p == PAR_ODD) ? ~^b : ^b;
   endfunction : par_bit

   function automatic logic [15:0] bit_cycles(input logic [2:0] sel, input int clkHz);
      int baud;
      case (sel)
         3'h0:    baud = 2400;
         3'h1:    baud = 4800;
         3'h2:    baud = 9600;
         3'h3:    baud = 19200;
         3'h4:    baud = 38400;
         3'h5:    baud = 57600;
         3'h6:    baud = 76800;
         default: baud = 115200;
      endcase
      return 16'(clkHz / baud);
   endfunction : bit_cycles

endpackage : modbus_pkg

/* File: modbus_rtu_slave_framer.sv */
// Contract
// - start bit, then eight data bits, least significant first
// - parity modes use one parity and one stop bit; no parity uses two stops
// - a reply starts only after 3.5 character times of silence
// - silence is counted in character times of the selected baud rate
// - first byte after silence is the address field
// - after the last character the line stays silent 3.5 characters before anything new
// - telegram characters are sent back to back
// - silence over 1.5 characters mid-frame flushes it; next byte is an address
// - bytes within 1.5 characters join the previous telegram; crc then fails silently
// - receiver watches the line at all times, silence included
// - incomplete telegrams raise an error flag
// - address zero is broadcast: accepted, never answered
// - address is eight bits; own address valid from 1 to 247
// - reply carries the slave's own address
// - function field is one byte, code 0x01 to 0xFF
// - normal reply echoes the function code
// - exception reply sets the function code's top bit
// - exception reply puts the error cause into the data field
// - every telegram ends with a 16-bit crc over all prior bytes
// - receiver recomputes crc; mismatch drops the telegram without reply
// - crc low byte first, high byte last
// - baud rates 2400 to 115200 selectable, timing follows the rate
// - after reset the format is even parity, one stop bit
//
// Purpose: framing layer of a modbus rtu slave on a half-duplex serial line
// Assumes: rxLine synchronous to clock; reply data bytes are queued in the fifo ahead of the serialiser
// Notes: a reply stalls with a line gap if the fifo runs dry mid-telegram
`timescale 1ns/1ps

module tx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   count;
   } fifo_state_t;

   fifo_state_t      f_q;
   fifo_state_t      f_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // pointers wrap naturally, so depth must be a power of two
   assign inReady  = f_q.count != (AW + 1)'(DEPTH);
   assign outValid = f_q.count != '0;
   assign outData  = mem[f_q.rd];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_comb begin
      f_d = f_q;
      if (push) begin
         f_d.wr = f_q.wr + 1'b1;
      end
      if (pop) begin
         f_d.rd = f_q.rd + 1'b1;
      end
      f_d.count = f_q.count + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
      if (push) begin
         mem[f_q.wr] <= inData;
      end
   end
endmodule : tx_fifo

module modbus_rtu_slave_framer
   import modbus_pkg::*;
#(
   parameter int CLK_HZ = CLK_HZ_DEFAULT
) (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       cfgLoad,
   input  wire logic [2:0] baudSel,
   input  parity_t         parityMode,
   input  wire logic [7:0] ownAddr,
   input  wire logic       rxLine,
   output logic            txLine,
   output logic            txDriveEn,
   output rx_byte_t        rxOut,
   output logic            rxValid,
   output logic            frameDone,
   output frame_status_t   frameStatus,
   output logic            respondPending,
   input  wire logic       txStart,
   input  wire logic       txException,
   input  wire logic [7:0] txExcCode,
   input  tx_word_t        txIn,
   input  wire logic       txInValid,
   output logic            txInReady,
   output logic            txBusy
);
   framer_state_t s_q;
   framer_state_t s_d;
   tx_word_t      fifoOut;
   logic          fifoValid;
   logic          fifoPop;
   logic [15:0]   bitCyc;
   logic [15:0]   bitReload;
   logic [15:0]   halfReload;
   logic          byteDone;
   logic          byteErr;
   logic          ownValid;
   logic          loadGo;
   logic [7:0]    loadByte;
   tx_phase_t     nextPhase;

   tx_fifo #(
      .WIDTH ($bits(tx_word_t)),
      .DEPTH (TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .inData   (txIn),
      .inValid  (txInValid),
      .inReady  (txInReady),
      .outData  (fifoOut),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   // every timer derives from the selected baud, never from absolute time
   assign bitCyc     = bit_cycles(s_q.baud, CLK_HZ);
   assign bitReload  = bitCyc - 16'h0001;
   assign halfReload = {1'b0, bitCyc[15:1]} - 16'h0001;
   assign ownValid   = (ownAddr != ADDR_BROADCAST) && (ownAddr <= ADDR_MAX);

   always_comb begin
      s_d           = s_q;
      s_d.rxValid   = 1'b0;
      s_d.frameDone = 1'b0;
      byteDone      = 1'b0;
      byteErr       = 1'b0;
      fifoPop       = 1'b0;
      loadGo        = 1'b0;
      loadByte      = 8'h00;
      nextPhase     = s_q.txPhase;

      if (cfgLoad) begin
         s_d.parity = parityMode;
         s_d.baud   = baudSel;
      end

      // receiver: samples mid-bit, one start, eight data, optional parity, stop
      case (s_q.rxState)
         RX_IDLE: begin
            if (!rxLine) begin
               s_d.rxState = RX_START;
               s_d.rxCnt   = halfReload;
            end
         end
         RX_START: begin
            if (s_q.rxCnt == 16'h0000) begin
               // a start bit gone high by mid-bit is a glitch, not a character
               s_d.rxState = rxLine ? RX_IDLE : RX_DATA;
               s_d.rxCnt   = bitReload;
               s_d.rxIdx   = 3'h0;
               s_d.rxErr   = 1'b0;
            end else begin
               s_d.rxCnt = s_q.rxCnt - 16'h0001;
            end
         end
         RX_DATA: begin
            if (s_q.rxCnt == 16'h0000) begin
               s_d.rxShift = {rxLine, s_q.rxShift[7:1]};
               s_d.rxIdx   = s_q.rxIdx + 3'h1;
               s_d.rxCnt   = bitReload;
               if (s_q.rxIdx == LAST_DATA_IDX) begin
                  s_d.rxState = (s_q.parity == PAR_NONE) ? RX_STOP : RX_PAR;
               end
            end else begin
               s_d.rxCnt = s_q.rxCnt - 16'h0001;
            end
         end
         RX_PAR: begin
            if (s_q.rxCnt == 16'h0000) begin
               s_d.rxErr   = rxLine != par_bit(s_q.parity, s_q.rxShift);
               s_d.rxState = RX_STOP;
               s_d.rxCnt   = bitReload;
            end else begin
               s_d.rxCnt = s_q.rxCnt - 16'h0001;
            end
         end
         RX_STOP: begin
            if (s_q.rxCnt == 16'h0000) begin
               // a second stop bit in no-parity mode just reads as idle line
               byteDone    = 1'b1;
               byteErr     = s_q.rxErr || !rxLine;
               s_d.rxState = RX_IDLE;
            end else begin
               s_d.rxCnt = s_q.rxCnt - 16'h0001;
            end
         end
         default: s_d.rxState = RX_IDLE;
      endcase

      // silence counter in half-bit units; own transmission counts as activity
      if (s_q.rxState != RX_IDLE || !rxLine || s_q.txDriveEn) begin
         s_d.silCnt    = 16'h0000;
         s_d.silHalves = 7'h00;
      end else if (s_q.silCnt >= halfReload) begin
         s_d.silCnt = 16'h0000;
         if (s_q.silHalves < SIL_END_HALVES) begin
            s_d.silHalves = s_q.silHalves + 7'h01;
         end
      end else begin
         s_d.silCnt = s_q.silCnt + 16'h0001;
      end

      // telegram delimiting
      if (byteDone) begin
         if (!s_q.inFrame || s_q.gapped) begin
            if (s_q.inFrame) begin
               s_d.frameDone = 1'b1;
               s_d.status    = '{ok: 1'b0, broadcast: s_q.broadcast, crcError: 1'b0, incomplete: 1'b1};
            end
            s_d.inFrame        = 1'b1;
            s_d.gapped         = 1'b0;
            s_d.byteCnt        = 3'h1;
            s_d.frameBad       = byteErr;
            s_d.crc            = crc16_byte(CRC_INIT, s_q.rxShift);
            s_d.broadcast      = s_q.rxShift == ADDR_BROADCAST;
            s_d.addrMatch      = (s_q.rxShift == ADDR_BROADCAST) || (ownValid && s_q.rxShift == ownAddr);
            s_d.respondPending = 1'b0;
         end else begin
            // late bytes simply extend the telegram, and the crc catches it
            s_d.crc      = crc16_byte(s_q.crc, s_q.rxShift);
            s_d.frameBad = s_q.frameBad || byteErr;
            if (s_q.byteCnt != 3'h7) begin
               s_d.byteCnt = s_q.byteCnt + 3'h1;
            end
            if (s_q.byteCnt == 3'h1) begin
               s_d.reqFunc = s_q.rxShift;
            end
            if (s_q.addrMatch) begin
               s_d.rxValid = 1'b1;
               s_d.rxOut   = '{data: s_q.rxShift, first: s_q.byteCnt == 3'h1};
            end
         end
      end else if (s_q.inFrame && s_q.silHalves >= SIL_END_HALVES) begin
         s_d.inFrame           = 1'b0;
         s_d.frameDone         = 1'b1;
         s_d.status.broadcast  = s_q.broadcast;
         s_d.status.incomplete = s_q.byteCnt < MIN_FRAME_BYTES;
         // parity faults are folded into the crc verdict: both drop silently
         s_d.status.crcError   = (s_q.byteCnt >= MIN_FRAME_BYTES) &&
                                 (s_q.crc != CRC_RESIDUE || s_q.frameBad);
         s_d.status.ok         = s_q.addrMatch && s_q.byteCnt >= MIN_FRAME_BYTES &&
                                 s_q.crc == CRC_RESIDUE && !s_q.frameBad;
         s_d.respondPending    = s_q.addrMatch && !s_q.broadcast && s_q.byteCnt >= MIN_FRAME_BYTES &&
                                 s_q.crc == CRC_RESIDUE && !s_q.frameBad;
      end else if (s_q.inFrame && s_q.silHalves >= SIL_GAP_HALVES) begin
         s_d.gapped = 1'b1;
      end

      // transmitter
      case (s_q.txState)
         TX_IDLE: begin
            if (txStart && s_q.respondPending) begin
               s_d.respondPending = 1'b0;
               s_d.txExc          = txException;
               s_d.txExcCode      = txExcCode;
               s_d.txPhase        = PH_ADDR;
               s_d.txState        = TX_WAIT;
            end
         end
         TX_WAIT: begin
            if (s_q.silHalves >= SIL_END_HALVES && s_q.rxState == RX_IDLE) begin
               s_d.txState   = TX_LOAD;
               s_d.txDriveEn = 1'b1;
            end
         end
         TX_LOAD: begin
            loadGo = 1'b1;
            case (s_q.txPhase)
               PH_ADDR: begin
                  loadByte  = ownAddr;
                  nextPhase = PH_FUNC;
               end
               PH_FUNC: begin
                  loadByte  = s_q.txExc ? (s_q.reqFunc | FUNC_EXC_FLAG) : s_q.reqFunc;
                  nextPhase = s_q.txExc ? PH_EXC : PH_DATA;
               end
               PH_EXC: begin
                  loadByte  = s_q.txExcCode;
                  nextPhase = PH_CRCLO;
               end
               PH_DATA: begin
                  loadGo    = fifoValid;
                  fifoPop   = fifoValid;
                  loadByte  = fifoOut.data;
                  nextPhase = fifoOut.last ? PH_CRCLO : PH_DATA;
               end
               PH_CRCLO: begin
                  loadByte  = s_q.txCrc[7:0];
                  nextPhase = PH_CRCHI;
               end
               PH_CRCHI: begin
                  loadByte  = s_q.txCrc[15:8];
                  nextPhase = PH_DONE;
               end
               default: begin
                  loadGo        = 1'b0;
                  s_d.txState   = TX_IDLE;
                  s_d.txDriveEn = 1'b0;
                  s_d.txLine    = 1'b1;
               end
            endcase
            if (loadGo) begin
               if (s_q.txPhase < PH_CRCLO) begin
                  s_d.txCrc = crc16_byte((s_q.txPhase == PH_ADDR) ? CRC_INIT : s_q.txCrc, loadByte);
               end
               s_d.txShift = {1'b1, (s_q.parity == PAR_NONE) ? 1'b1 : par_bit(s_q.parity, loadByte),
                              loadByte, 1'b0};
               s_d.txLine  = 1'b0;
               s_d.txCnt   = bitReload;
               s_d.txIdx   = 4'h0;
               s_d.txPhase = nextPhase;
               s_d.txState = TX_SEND;
            end
         end
         TX_SEND: begin
            if (s_q.txCnt != 16'h0000) begin
               s_d.txCnt = s_q.txCnt - 16'h0001;
            end else if (s_q.txIdx == LAST_BIT_IDX) begin
               s_d.txState = TX_LOAD;
            end else begin
               s_d.txShift = {1'b1, s_q.txShift[10:1]};
               s_d.txLine  = s_q.txShift[1];
               s_d.txIdx   = s_q.txIdx + 4'h1;
               s_d.txCnt   = bitReload;
            end
         end
         default: s_d.txState = TX_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_q <= FRAMER_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign txLine         = s_q.txLine;
   assign txDriveEn      = s_q.txDriveEn;
   assign rxOut          = s_q.rxOut;
   assign rxValid        = s_q.rxValid;
   assign frameDone      = s_q.frameDone;
   assign frameStatus    = s_q.status;
   assign respondPending = s_q.respondPending;
   assign txBusy         = s_q.txState != TX_IDLE;

endmodule : modbus_rtu_slave_framer

/* File: modbus_rtu_slave_framer_assertions.sv */
// Purpose: concurrent checks on the framer's ports
// Assumes: one clock domain, synchronous active-high reset
// Notes: the reply silence floor uses the fastest baud, so it is a lower bound only
`timescale 1ns/1ps
module modbus_rtu_slave_framer_checker
   import modbus_pkg::*;
#(
   parameter int CLK_HZ = CLK_HZ_DEFAULT
) (
   input  wire logic    clock,
   input  wire logic    sys_rst,
   input  wire logic    rxLine,
   input  wire logic    txLine,
   input  wire logic    txDriveEn,
   input  wire logic    frameDone,
   input  frame_status_t frameStatus,
   input  wire logic    respondPending,
   input  wire logic    txStart,
   input  wire logic    txBusy
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   localparam int MIN_SIL = 38 * (CLK_HZ / 115200);
   logic [19:0] quietCnt_q;
   // saturates so a long idle line never wraps back under the floor
   always_ff @(posedge clock) begin
      if (sys_rst || !rxLine) quietCnt_q <= '0;
      else if (quietCnt_q != '1) quietCnt_q <= quietCnt_q + 20'h1;
   end
   chk_idle_high: assert property (!txDriveEn |-> txLine)
      else $error("line not idle high while driver is off");
   chk_start_driven: assert property ($fell(txLine) |-> txDriveEn)
      else $error("start bit sent without driver enable");
   chk_reply_silence: assert property ($rose(txDriveEn) |-> quietCnt_q >= MIN_SIL)
      else $error("reply started without leading silence");
   chk_drive_busy: assert property (txDriveEn |-> txBusy)
      else $error("driver on outside a reply");
   chk_take_start: assert property (txStart && respondPending && !txBusy |=> txBusy && !respondPending)
      else $error("accepted start did not launch the reply");
   chk_bcast_quiet: assert property (frameDone ##1 frameStatus.broadcast |-> !respondPending)
      else $error("broadcast frame armed a reply");
   chk_crc_quiet: assert property (frameDone ##1 frameStatus.crcError |-> !respondPending)
      else $error("crc failure armed a reply");
   chk_ok_clean: assert property (frameDone ##1 frameStatus.ok |-> !frameStatus.crcError && !frameStatus.incomplete)
      else $error("good status mixed with error flags");
   chk_done_pulse: assert property (frameDone |=> !frameDone [*2])
      else $error("frame end pulse too long");
   cover property ($rose(txDriveEn));
   cover property (frameDone ##1 frameStatus.broadcast);
   cover property (frameDone ##1 frameStatus.incomplete);
   cover property (frameDone ##1 frameStatus.crcError);
endmodule : modbus_rtu_slave_framer_checker

/* File: tb_modbus_rtu_slave_framer.sv */
// Purpose: directed regression of the modbus rtu slave framer
// Assumes: master model drives the receive line and collects reply characters
// Notes: clock rate is cut so one bit at the fastest baud lasts 4 cycles
`timescale 1ns/1ps
module tb_modbus_rtu_slave_framer
   import modbus_pkg::*;
;
   localparam int SIM_HZ = 460800;
   logic          clock, sys_rst, cfgLoad, rxLine, txLine, txDriveEn, rxValid, frameDone;
   logic          respondPending, txStart, txException, txInValid, txInReady, txBusy;
   logic [2:0]    baudSel;
   logic [7:0]    ownAddr, txExcCode;
   parity_t       parityMode;
   rx_byte_t      rxOut;
   frame_status_t frameStatus;
   tx_word_t      txIn;
   int            fail_count = 0;
   int            n_compared = 0;
   logic [7:0]    b[$];
   logic [7:0]    e[$];
   rx_byte_t      rxQ[$];
   frame_status_t stQ[$];
   logic          doneSeen = 1'b0;
   always #4 clock = ~clock;
   modbus_rtu_slave_framer #(.CLK_HZ(SIM_HZ)) dut_u (.clock(clock), .sys_rst(sys_rst), .cfgLoad(cfgLoad),
      .baudSel(baudSel), .parityMode(parityMode), .ownAddr(ownAddr), .rxLine(rxLine), .txLine(txLine),
      .txDriveEn(txDriveEn), .rxOut(rxOut), .rxValid(rxValid), .frameDone(frameDone), .frameStatus(frameStatus),
      .respondPending(respondPending), .txStart(txStart), .txException(txException), .txExcCode(txExcCode),
      .txIn(txIn), .txInValid(txInValid), .txInReady(txInReady), .txBusy(txBusy));
   modbus_master_model master_u (.clock(clock), .rxLine(rxLine), .txLine(txLine));
   // status is taken one cycle after the end pulse, when it has surely settled
   always @(negedge clock) begin
      if (rxValid === 1'b1) rxQ.push_back(rxOut);
      if (doneSeen) stQ.push_back(frameStatus);
      doneSeen = (frameDone === 1'b1);
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic void seal(ref logic [7:0] q[$]);
      logic [15:0] c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endfunction : seal
   function automatic logic pbit(input logic [7:0] d);
      return (master_u.par == PAR_NONE) ? 1'b1 : (master_u.par == PAR_ODD) ? ~^d : ^d;
   endfunction : pbit
   task automatic send(input int pre, input int nDone);
      rxQ.delete();
      stQ.delete();
      master_u.send_frame(b, pre);
      for (int i = 0; i < 30000 && stQ.size() < nDone; i++) @(posedge clock);
      #1;
      chk("frame count", 16'(nDone), 16'(stQ.size()));
   endtask : send
   task automatic reply(input logic exc, input logic [7:0] code);
      master_u.gotQ.delete();
      txException = exc;
      txExcCode = code;
      txStart = 1'b1;
      @(posedge clock);
      #1 txStart = 1'b0;
      for (int i = 0; i < 30000 && (txBusy !== 1'b0 || master_u.gotQ.size() < e.size()); i++) @(posedge clock);
      #1;
      chk("reply length", 16'(e.size()), 16'(master_u.gotQ.size()));
      foreach (e[i]) chk("reply char", {7'h01, pbit(e[i]), e[i]}, {6'h00, master_u.gotQ[i]});
   endtask : reply
   task automatic cfg(input parity_t p);
      baudSel = 3'h7;
      parityMode = p;
      cfgLoad = 1'b1;
      @(posedge clock);
      #1 cfgLoad = 1'b0;
      master_u.bitCyc = SIM_HZ / 115200;
      master_u.par = p;
   endtask : cfg
   task automatic tally_and_finish;
      if (fail_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (90000) @(posedge clock);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      clock = 1'b0; sys_rst = 1'b1; cfgLoad = 1'b0; baudSel = 3'h0; parityMode = PAR_EVEN;
      ownAddr = 8'h11; txStart = 1'b0; txException = 1'b0; txExcCode = 8'h00; txIn = '0; txInValid = 1'b0;
      repeat (6) @(posedge clock);
      #1 sys_rst = 1'b0;
      chk("idle line", 16'h1, {15'h0, txLine});
      chk("idle outputs", 16'h0, {11'h0, txDriveEn, respondPending, txBusy, frameStatus.ok, frameStatus.incomplete});
      chk("fifo ready", 16'h1, {15'h0, txInReady});
      b = '{8'h11, 8'h03}; // default format: even parity, 9600 baud
      seal(b);
      send(44, 1);
      chk("request ok", 16'h3, {14'h0, stQ[0].ok, respondPending});
      chk("rx count", 16'h3, 16'(rxQ.size()));
      foreach (rxQ[i]) chk("rx byte", {7'h00, b[i + 1], i == 0}, {7'h00, rxQ[i]});
      e = '{8'h11, 8'h83, 8'h02};
      seal(e);
      reply(1'b1, 8'h02);
      cfg(PAR_ODD);
      for (int i = 0; i < 8; i++) begin
         txIn = '{data: 8'hA0 + 8'(i), last: (i == 7)};
         txInValid = 1'b1;
         @(posedge clock);
         #1;
      end
      txInValid = 1'b0;
      chk("fifo full", 16'h0, {15'h0, txInReady});
      b = '{8'h11, 8'h06, 8'h01, 8'h02};
      seal(b);
      send(44, 1);
      chk("pending", 16'h1, {15'h0, respondPending});
      e = '{8'h11, 8'h06, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7};
      seal(e);
      reply(1'b0, 8'h00);
      chk("fifo drained", 16'h1, {15'h0, txInReady});
      cfg(PAR_NONE);
      b = '{8'h00, 8'h05};
      seal(b);
      send(44, 1);
      chk("broadcast", 16'h2, {14'h0, stQ[0].broadcast, respondPending});
      txStart = 1'b1;
      @(posedge clock);
      #1 txStart = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk("no reply", 16'h0, {14'h0, txBusy, txDriveEn});
      b = '{8'h22, 8'h05};
      seal(b);
      send(44, 1);
      chk("foreign", 16'h0, {14'h0, stQ[0].ok, respondPending});
      chk("foreign bytes", 16'h0, 16'(rxQ.size()));
      b = '{8'h11, 8'h05, 8'hAA, 8'hBB};
      send(44, 1);
      chk("bad crc", 16'h2, {14'h0, stQ[0].crcError, respondPending});
      b = '{8'h11, 8'h05};
      master_u.send_frame(b, 44);
      b = '{8'h11, 8'h04};
      seal(b);
      send(22, 2);
      chk("flushed", 16'h3, {14'h0, stQ[0].incomplete, stQ[1].ok});
      b = '{8'h11, 8'h03};
      seal(b);
      master_u.send_frame(b, 44);
      send(11, 1);
      chk("appended", 16'h2, {14'h0, stQ[0].crcError, respondPending});
      tally_and_finish();
   end
endmodule : tb_modbus_rtu_slave_framer
bind modbus_rtu_slave_framer modbus_rtu_slave_framer_checker #(.CLK_HZ(CLK_HZ)) chk_u (.clock(clock),
   .sys_rst(sys_rst), .rxLine(rxLine), .txLine(txLine), .txDriveEn(txDriveEn), .frameDone(frameDone),
   .frameStatus(frameStatus), .respondPending(respondPending), .txStart(txStart), .txBusy(txBusy));
